// >>> hw/sbpp_device.sv
`timescale 1ns/1ns
`include "sbpp_defs.svh"
// How it works
// [R1] No mode input; identical in every control mode
// [R2] Host pulls attention low for command bytes
// [R3] Host owns clock; device only samples it
// [R4] Data open-drain, driven by both ends
// [R5] Listener holds data low until clock high
// [R6] Willing 20-200us after clock; late means EOI
// [R7] Host waits 20us before releasing attention
// [R8] Decode talk, listen, untalk, unlisten commands
// [R9] Addresses 0-30; answer only printer class 4-7
// [R10] Decode channel open and close, channels 0-15
// [R11] Channels 0/1 are program read/write
// [R12] Channels 12-14 serve any file type
// [R13] Channel 15 is unit command channel
// [R14] Decode normal secondary, five-bit value
// [R15] Eight bits, LSB first, clocked by clock
// [R16] Listen bytes 24H/25H mean devices 4/5
// [R17] Reset idles port, releases data, clears roles
// [R18] Timing counted in one-microsecond ticks
module sbpp_device #(
  parameter logic [4:0] DEV_ADDR = `SBPP_DEF_DEV_ADDR, // Own bus address
  parameter int TICK_CYC = `SBPP_TICK_CYC // Cycles per microsecond tick
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic ce, // Clock enable
  sbpp_if.dev bus, // Serial bus
  output logic rx_valid, // Data byte pulse
  output logic [7:0] rx_data, // Received data byte
  output logic rx_eoi, // Byte was last of stream
  output logic sec_valid, // Secondary byte pulse
  output sbpp_pkg::sbpp_cmd_type sec_kind, // Open, close or normal
  output logic [4:0] sec_chan, // Channel or secondary value
  output sbpp_pkg::sbpp_chan_type chan_class, // Channel meaning
  output logic listener, // Listener role held
  output logic talker // Talker role held
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  // A non-printer address never matches, so the port never takes the listener or talker role
  localparam logic ADDR_OK = (DEV_ADDR >= `SBPP_PRN_ADDR_LO) && (DEV_ADDR <= `SBPP_PRN_ADDR_HI);

  sbpp_pkg::sbpp_dev_state_type st_q, st_prev_q;
  sbpp_pkg::sbpp_cmd_type kind;
  logic [7:0] pre_q;
  logic tick;
  logic [`SBPP_TMR_W-1:0] tmr_q, tmr;
  logic atn_s1_q, atn_s2_q, atn_s3_q;
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic dat_s1_q, dat_s2_q;
  logic atn_fall, atn_rise, clk_rise, clk_fall;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic byte_atn_q;
  logic eoi_seen_q;
  logic byte_done;
  logic addr_hit;
  logic addressed_q;
  logic oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus lines come from another domain: two flops before use
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      atn_s1_q <= 1'b1;
      atn_s2_q <= 1'b1;
      atn_s3_q <= 1'b1;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else if (ce) begin
      atn_s1_q <= bus.atn_n;
      atn_s2_q <= atn_s1_q;
      atn_s3_q <= atn_s2_q;
      clk_s1_q <= bus.clk_line; // see [R3]
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= bus.data_level;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign atn_fall = atn_s3_q && !atn_s2_q;
  assign atn_rise = !atn_s3_q && atn_s2_q;
  assign clk_rise = !clk_s3_q && clk_s2_q;
  assign clk_fall = clk_s3_q && !clk_s2_q;

  ////////////////////////////////////////////////////////////////////////////////
  assign tick = (pre_q == TICK_LAST);
  // Reads zero on entry; a long hold must not cut the willing delay short
  assign tmr = (st_q != st_prev_q) ? '0 : tmr_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 8'h00;
    end else if (ce) begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01; // see [R18]
    end
  end

  // Resolution is one tick; restart lags state entry by one cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_prev_q <= sbpp_pkg::SBPP_DEV_IDLE;
      tmr_q <= '0;
    end else if (ce) begin
      st_prev_q <= st_q;
      if (st_q != st_prev_q) tmr_q <= '0;
      else if (tick && !(&tmr_q)) tmr_q <= tmr_q + 1'b1; // see [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign byte_done = (st_q == sbpp_pkg::SBPP_DEV_BITS) && clk_fall && (cnt_q == `SBPP_DEV_BITS);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= sbpp_pkg::SBPP_DEV_IDLE; // see [R17]
    end else if (ce) begin
      if (atn_fall) begin
        st_q <= sbpp_pkg::SBPP_DEV_HOLD; // see [R2]
      end else begin
        case (st_q)
          sbpp_pkg::SBPP_DEV_IDLE: begin
            st_q <= sbpp_pkg::SBPP_DEV_IDLE;
          end
          sbpp_pkg::SBPP_DEV_HOLD: begin
            if (atn_s2_q && !listener) st_q <= sbpp_pkg::SBPP_DEV_IDLE;
            else if (clk_s2_q) st_q <= sbpp_pkg::SBPP_DEV_DELAY; // see [R5]
          end
          sbpp_pkg::SBPP_DEV_DELAY: begin
            if (tmr >= `SBPP_RFD_DELAY_US) st_q <= sbpp_pkg::SBPP_DEV_READY; // see [R6]
          end
          sbpp_pkg::SBPP_DEV_READY: begin
            if (clk_fall) st_q <= sbpp_pkg::SBPP_DEV_BITS;
            else if (!eoi_seen_q && tmr >= `SBPP_EOI_DETECT_US) begin
              st_q <= sbpp_pkg::SBPP_DEV_EOIACK; // see [R6]
            end
          end
          sbpp_pkg::SBPP_DEV_EOIACK: begin
            if (tmr >= `SBPP_EOI_HOLD_US) st_q <= sbpp_pkg::SBPP_DEV_READY;
          end
          sbpp_pkg::SBPP_DEV_BITS: begin
            if (byte_done) st_q <= sbpp_pkg::SBPP_DEV_HOLD;
            else if (atn_rise && !listener) st_q <= sbpp_pkg::SBPP_DEV_IDLE;
          end
          default: st_q <= sbpp_pkg::SBPP_DEV_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eoi_seen_q <= 1'b0;
    end else if (ce) begin
      if (st_q == sbpp_pkg::SBPP_DEV_EOIACK) eoi_seen_q <= 1'b1;
      else if (st_q == sbpp_pkg::SBPP_DEV_HOLD || st_q == sbpp_pkg::SBPP_DEV_IDLE) begin
        eoi_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      byte_atn_q <= 1'b0;
    end else if (ce) begin
      if (st_q == sbpp_pkg::SBPP_DEV_READY) begin
        cnt_q <= 4'h0;
      end else if (st_q == sbpp_pkg::SBPP_DEV_BITS && clk_rise && cnt_q != `SBPP_DEV_BITS) begin
        shift_q <= {dat_s2_q, shift_q[7:1]}; // see [R15]
        cnt_q <= cnt_q + 4'h1;
        byte_atn_q <= !atn_s2_q;
      end
    end
  end

  assign kind = sbpp_pkg::sbpp_decode(shift_q); // see [R8]
  // Own listen byte is 24H for device 4, 25H for device 5
  assign addr_hit = ADDR_OK && (shift_q[4:0] == DEV_ADDR); // see [R9] see [R16]

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      listener <= 1'b0; // see [R17]
      talker <= 1'b0;
      addressed_q <= 1'b0;
    end else if (ce && byte_done && byte_atn_q) begin
      case (kind)
        sbpp_pkg::SBPP_CMD_LISTEN: begin
          if (addr_hit) listener <= 1'b1; // see [R8]
          addressed_q <= addr_hit;
        end
        sbpp_pkg::SBPP_CMD_TALK: begin
          if (addr_hit) talker <= 1'b1;
          addressed_q <= addr_hit;
        end
        sbpp_pkg::SBPP_CMD_UNLISTEN: begin
          listener <= 1'b0;
          addressed_q <= 1'b0;
        end
        sbpp_pkg::SBPP_CMD_UNTALK: begin
          talker <= 1'b0;
          addressed_q <= 1'b0;
        end
        default: addressed_q <= addressed_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_eoi <= 1'b0;
    end else if (ce) begin
      rx_valid <= byte_done && !byte_atn_q && listener;
      if (byte_done && !byte_atn_q && listener) begin
        rx_data <= shift_q;
        rx_eoi <= eoi_seen_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_valid <= 1'b0;
      sec_kind <= sbpp_pkg::SBPP_CMD_NONE;
      sec_chan <= 5'h00;
      chan_class <= sbpp_pkg::SBPP_CH_OTHER;
    end else if (ce) begin
      sec_valid <= 1'b0;
      if (byte_done && byte_atn_q && addressed_q) begin
        if (kind == sbpp_pkg::SBPP_CMD_OPEN || kind == sbpp_pkg::SBPP_CMD_CLOSE) begin
          sec_valid <= 1'b1; // see [R10]
          sec_kind <= kind;
          sec_chan <= {1'b0, shift_q[3:0]};
          // see [R11] see [R12] see [R13]
          chan_class <= sbpp_pkg::sbpp_chan_class(shift_q[3:0]);
        end else if (kind == sbpp_pkg::SBPP_CMD_SEC) begin
          sec_valid <= 1'b1; // see [R14]
          sec_kind <= kind;
          sec_chan <= shift_q[4:0];
          chan_class <= sbpp_pkg::SBPP_CH_OTHER;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pull data low while holding off or acknowledging
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 1'b0; // see [R17]
    end else if (ce) begin
      oe_q <= (st_q == sbpp_pkg::SBPP_DEV_HOLD) || (st_q == sbpp_pkg::SBPP_DEV_DELAY) ||
              (st_q == sbpp_pkg::SBPP_DEV_EOIACK) || atn_fall; // see [R4] see [R5]
    end
  end

  // Mode selection lives elsewhere; nothing here depends on it, see [R1]
  assign bus.dev_data_o = 1'b0;
  assign bus.dev_data_oe = oe_q;
  assign bus.service_request_line = 1'b1;

endmodule : sbpp_device

// >>> hw/sbpp_defs.svh
`ifndef SBPP_DEFS_SVH
`define SBPP_DEFS_SVH

// Clock and microsecond tick
`define SBPP_CLK_PERIOD_NS 4
`define SBPP_NS_PER_US 1000
`define SBPP_TICK_CYC (`SBPP_NS_PER_US / `SBPP_CLK_PERIOD_NS)
`define SBPP_TMR_W 11

// Listener timing, microseconds
`define SBPP_RFD_DELAY_US 11'd40
`define SBPP_EOI_DETECT_US 11'd200
`define SBPP_EOI_HOLD_US 11'd100

// Talker timing, microseconds
`define SBPP_ATN_RESP_US 11'd1000
`define SBPP_BYTE_GAP_US 11'd100
`define SBPP_SETUP_US 11'd60
`define SBPP_VALID_US 11'd80
`define SBPP_FRAME_US 11'd1000
`define SBPP_ATN_REL_US 11'd80

// Byte framing
`define SBPP_DEV_BITS 4'd8
`define SBPP_HOST_LAST_BIT 3'd7

// Command encodings
`define SBPP_CODE_UNTALK 8'h5f
`define SBPP_CODE_UNLISTEN 8'h3f
`define SBPP_PFX_TALK 3'h2
`define SBPP_PFX_LISTEN 3'h1
`define SBPP_PFX_SEC 3'h3
`define SBPP_PFX_OPEN 4'hf
`define SBPP_PFX_CLOSE 4'he

// Address and channel classes
`define SBPP_DEF_DEV_ADDR 5'd4
`define SBPP_PRN_ADDR_LO 5'd4
`define SBPP_PRN_ADDR_HI 5'd7
`define SBPP_CH_PROG_RD 4'h0
`define SBPP_CH_PROG_WR 4'h1
`define SBPP_CH_ANY_LO 4'hc
`define SBPP_CH_ANY_HI 4'he
`define SBPP_CH_UNIT 4'hf

`endif

// >>> hw/sbpp_pkg.sv
`include "sbpp_defs.svh"
package sbpp_pkg;

  typedef enum logic [2:0] {
    SBPP_CMD_NONE = 3'h0,
    SBPP_CMD_TALK = 3'h1,
    SBPP_CMD_LISTEN = 3'h2,
    SBPP_CMD_UNTALK = 3'h3,
    SBPP_CMD_UNLISTEN = 3'h4,
    SBPP_CMD_OPEN = 3'h5,
    SBPP_CMD_CLOSE = 3'h6,
    SBPP_CMD_SEC = 3'h7
  } sbpp_cmd_type;

  typedef enum logic [2:0] {
    SBPP_CH_OTHER = 3'h0,
    SBPP_CH_PROG_READ = 3'h1,
    SBPP_CH_PROG_WRITE = 3'h2,
    SBPP_CH_ANY_FILE = 3'h3,
    SBPP_CH_UNIT_CMD = 3'h4
  } sbpp_chan_type;

  typedef enum logic [5:0] {
    SBPP_DEV_IDLE = 6'h01,
    SBPP_DEV_HOLD = 6'h02,
    SBPP_DEV_DELAY = 6'h04,
    SBPP_DEV_READY = 6'h08,
    SBPP_DEV_EOIACK = 6'h10,
    SBPP_DEV_BITS = 6'h20
  } sbpp_dev_state_type;

  typedef enum logic [9:0] {
    SBPP_HST_IDLE = 10'h001,
    SBPP_HST_ATTN = 10'h002,
    SBPP_HST_GAP = 10'h004,
    SBPP_HST_OFFER = 10'h008,
    SBPP_HST_EOIW = 10'h010,
    SBPP_HST_EOIR = 10'h020,
    SBPP_HST_BLOW = 10'h040,
    SBPP_HST_BHIGH = 10'h080,
    SBPP_HST_FRAME = 10'h100,
    SBPP_HST_TURN = 10'h200
  } sbpp_hst_state_type;

  function automatic sbpp_cmd_type sbpp_decode(input logic [7:0] b);
    if (b == `SBPP_CODE_UNTALK) return SBPP_CMD_UNTALK;
    else if (b == `SBPP_CODE_UNLISTEN) return SBPP_CMD_UNLISTEN;
    else if (b[7:5] == `SBPP_PFX_TALK) return SBPP_CMD_TALK;
    else if (b[7:5] == `SBPP_PFX_LISTEN) return SBPP_CMD_LISTEN;
    else if (b[7:5] == `SBPP_PFX_SEC) return SBPP_CMD_SEC;
    else if (b[7:4] == `SBPP_PFX_OPEN) return SBPP_CMD_OPEN;
    else if (b[7:4] == `SBPP_PFX_CLOSE) return SBPP_CMD_CLOSE;
    else return SBPP_CMD_NONE;
  endfunction : sbpp_decode

  function automatic sbpp_chan_type sbpp_chan_class(input logic [3:0] c);
    if (c == `SBPP_CH_PROG_RD) return SBPP_CH_PROG_READ;
    else if (c == `SBPP_CH_PROG_WR) return SBPP_CH_PROG_WRITE;
    else if (c >= `SBPP_CH_ANY_LO && c <= `SBPP_CH_ANY_HI) return SBPP_CH_ANY_FILE;
    else if (c == `SBPP_CH_UNIT) return SBPP_CH_UNIT_CMD;
    else return SBPP_CH_OTHER;
  endfunction : sbpp_chan_class

endpackage : sbpp_pkg

// >>> hw/sbpp_if.sv
`timescale 1ns/1ns
interface sbpp_if;
  logic atn_n;
  logic clk_line;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic service_request_line;
  logic data_level;

  // Open-drain wired level: any enabled low driver wins
  assign data_level = !((host_data_oe && !host_data_o) || (dev_data_oe && !dev_data_o));

  modport host (
    output atn_n,
    output clk_line,
    output host_data_o,
    output host_data_oe,
    input data_level,
    input service_request_line
  );

  modport dev (
    input atn_n,
    input clk_line,
    input data_level,
    output dev_data_o,
    output dev_data_oe,
    output service_request_line
  );
endinterface : sbpp_if

// >>> hw/sbpp_host.sv
`timescale 1ns/1ns
`include "sbpp_defs.svh"
module sbpp_host #(
  parameter int TICK_CYC = `SBPP_TICK_CYC // Cycles per microsecond tick
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic ce, // Clock enable
  sbpp_if.host bus, // Serial bus
  input wire logic tx_valid, // Send request
  input wire logic [7:0] tx_data, // Byte to send
  input wire logic tx_atn, // Send as command byte
  input wire logic tx_atn_end, // Release attention after byte
  input wire logic tx_eoi, // Mark as last data byte
  output logic tx_ready, // Idle, request accepted
  output logic tx_done, // Byte acknowledged pulse
  output logic err_absent, // No listener pulse
  output logic err_frame // No frame acknowledge pulse
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

  sbpp_pkg::sbpp_hst_state_type st_q, st_prev_q;
  logic [7:0] pre_q;
  logic tick;
  logic [`SBPP_TMR_W-1:0] tmr_q, tmr;
  logic dat_s1_q, dat_s2_q;
  logic [7:0] byte_q;
  logic [2:0] cnt_q;
  logic end_q, eoi_q;
  logic atn_n_q, clk_q, dat_oe_q;
  logic to_absent, to_frame;

  assign tick = (pre_q == TICK_LAST);
  // Reads zero on entry, so the last state's count never ends this one
  assign tmr = (st_q != st_prev_q) ? '0 : tmr_q;
  assign to_absent = (tmr >= `SBPP_ATN_RESP_US) && (st_q == sbpp_pkg::SBPP_HST_ATTN ||
                     st_q == sbpp_pkg::SBPP_HST_OFFER || st_q == sbpp_pkg::SBPP_HST_EOIW ||
                     st_q == sbpp_pkg::SBPP_HST_EOIR);
  assign to_frame = (st_q == sbpp_pkg::SBPP_HST_FRAME) && dat_s2_q && (tmr >= `SBPP_FRAME_US);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
      pre_q <= 8'h00;
    end else if (ce) begin
      dat_s1_q <= bus.data_level;
      dat_s2_q <= dat_s1_q;
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
    end
  end

  // Restart lags state entry by one cycle, well under a microsecond
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_prev_q <= sbpp_pkg::SBPP_HST_IDLE;
      tmr_q <= '0;
    end else if (ce) begin
      st_prev_q <= st_q;
      if (st_q != st_prev_q) tmr_q <= '0;
      else if (tick && !(&tmr_q)) tmr_q <= tmr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= sbpp_pkg::SBPP_HST_IDLE;
    end else if (ce) begin
      case (st_q)
        sbpp_pkg::SBPP_HST_IDLE: begin
          if (tx_valid) st_q <= (tx_atn && atn_n_q) ? sbpp_pkg::SBPP_HST_ATTN : sbpp_pkg::SBPP_HST_GAP;
        end
        sbpp_pkg::SBPP_HST_ATTN: begin
          if (to_absent) st_q <= sbpp_pkg::SBPP_HST_IDLE;
          else if (!dat_s2_q) st_q <= sbpp_pkg::SBPP_HST_GAP;
        end
        sbpp_pkg::SBPP_HST_GAP: begin
          if (tmr >= `SBPP_BYTE_GAP_US) st_q <= sbpp_pkg::SBPP_HST_OFFER;
        end
        sbpp_pkg::SBPP_HST_OFFER: begin
          if (to_absent) st_q <= sbpp_pkg::SBPP_HST_IDLE;
          else if (dat_s2_q) st_q <= eoi_q ? sbpp_pkg::SBPP_HST_EOIW : sbpp_pkg::SBPP_HST_BLOW; // see [R6]
        end
        sbpp_pkg::SBPP_HST_EOIW: begin
          if (to_absent) st_q <= sbpp_pkg::SBPP_HST_IDLE;
          else if (!dat_s2_q) st_q <= sbpp_pkg::SBPP_HST_EOIR;
        end
        sbpp_pkg::SBPP_HST_EOIR: begin
          if (to_absent) st_q <= sbpp_pkg::SBPP_HST_IDLE;
          else if (dat_s2_q) st_q <= sbpp_pkg::SBPP_HST_BLOW;
        end
        sbpp_pkg::SBPP_HST_BLOW: begin
          if (tmr >= `SBPP_SETUP_US) st_q <= sbpp_pkg::SBPP_HST_BHIGH;
        end
        sbpp_pkg::SBPP_HST_BHIGH: begin
          if (tmr >= `SBPP_VALID_US) begin
            st_q <= (cnt_q == `SBPP_HOST_LAST_BIT) ? sbpp_pkg::SBPP_HST_FRAME : sbpp_pkg::SBPP_HST_BLOW;
          end
        end
        sbpp_pkg::SBPP_HST_FRAME: begin
          if (to_frame) st_q <= sbpp_pkg::SBPP_HST_IDLE;
          else if (!dat_s2_q) st_q <= end_q ? sbpp_pkg::SBPP_HST_TURN : sbpp_pkg::SBPP_HST_IDLE;
        end
        sbpp_pkg::SBPP_HST_TURN: begin
          if (tmr >= `SBPP_ATN_REL_US) st_q <= sbpp_pkg::SBPP_HST_IDLE; // see [R7]
        end
        default: st_q <= sbpp_pkg::SBPP_HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_q <= 8'h00;
      end_q <= 1'b0;
      eoi_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (ce) begin
      if (st_q == sbpp_pkg::SBPP_HST_IDLE && tx_valid) begin
        byte_q <= tx_data;
        end_q <= tx_atn && tx_atn_end;
        eoi_q <= tx_eoi && !tx_atn;
        cnt_q <= 3'h0;
      end else if (st_q == sbpp_pkg::SBPP_HST_BHIGH && tmr >= `SBPP_VALID_US) begin
        cnt_q <= cnt_q + 3'h1; // see [R15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      atn_n_q <= 1'b1;
      clk_q <= 1'b0;
      dat_oe_q <= 1'b0;
    end else if (ce) begin
      if (st_q == sbpp_pkg::SBPP_HST_IDLE && tx_valid && tx_atn) atn_n_q <= 1'b0; // see [R2]
      else if (to_absent || to_frame) atn_n_q <= 1'b1;
      else if (st_q == sbpp_pkg::SBPP_HST_TURN && tmr >= `SBPP_ATN_REL_US) atn_n_q <= 1'b1;
      clk_q <= (st_q == sbpp_pkg::SBPP_HST_OFFER) || (st_q == sbpp_pkg::SBPP_HST_EOIW) ||
               (st_q == sbpp_pkg::SBPP_HST_EOIR) || (st_q == sbpp_pkg::SBPP_HST_BHIGH); // see [R3]
      dat_oe_q <= (st_q == sbpp_pkg::SBPP_HST_BLOW || st_q == sbpp_pkg::SBPP_HST_BHIGH) &&
                  !byte_q[cnt_q]; // see [R4]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ready <= 1'b0;
      tx_done <= 1'b0;
      err_absent <= 1'b0;
      err_frame <= 1'b0;
    end else if (ce) begin
      tx_ready <= (st_q == sbpp_pkg::SBPP_HST_IDLE) && !tx_valid;
      tx_done <= (st_q == sbpp_pkg::SBPP_HST_FRAME && !dat_s2_q && !end_q) ||
                 (st_q == sbpp_pkg::SBPP_HST_TURN && tmr >= `SBPP_ATN_REL_US);
      err_absent <= to_absent;
      err_frame <= to_frame;
    end
  end

  assign bus.atn_n = atn_n_q;
  assign bus.clk_line = clk_q;
  assign bus.host_data_o = 1'b0;
  assign bus.host_data_oe = dat_oe_q;

endmodule : sbpp_host

// >>> tb/sbpp_props.sv
`timescale 1ns/1ns
`include "sbpp_defs.svh"
module sbpp_props #(
  parameter int US = `SBPP_TICK_CYC // Cycles per microsecond
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic atn_n, // Attention line
  input wire logic clk_line, // Bus clock line
  input wire logic host_data_oe, // Host pulls data
  input wire logic dev_data_oe // Device pulls data
);
  logic [19:0] hi_q;
  logic [19:0] ack_q;
  logic rel_q;
  logic clk_q;
  logic [3:0] bits_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////
  // Time since clock release and since device pulled data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) hi_q <= 20'h00000;
    else hi_q <= clk_line ? hi_q + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) ack_q <= 20'h00000;
    else ack_q <= dev_data_oe ? ack_q + 20'h00001 : 20'h00000;
  end
  // Set once the listener lets go within this clock-high span
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) rel_q <= 1'b0;
    else if (!clk_line) rel_q <= 1'b0;
    else if (!dev_data_oe) rel_q <= 1'b1;
  end
  // Bit cells: clock rises while the device is not holding data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) clk_q <= 1'b0;
    else clk_q <= clk_line;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) bits_q <= 4'h0;
    else if (dev_data_oe) bits_q <= 4'h0;
    else if (clk_line && !clk_q) bits_q <= bits_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  a_hold_clk_low: assert property (
    !atn_n && !$past(atn_n) && !clk_line && !$past(clk_line) && $past(dev_data_oe)
    |-> dev_data_oe) else $error("listener let data go while clock low");
  a_willing_min: assert property (
    $fell(dev_data_oe) && clk_line |-> hi_q >= 20 * US)
    else $error("willing signalled too early");
  a_willing_max: assert property (
    clk_line && !rel_q |-> hi_q <= 200 * US) else $error("willing signalled too late");
  a_atn_resp: assert property (
    $fell(atn_n) |-> ##[1:16] dev_data_oe) else $error("no response to attention");
  a_reset_idle: assert property (
    $rose(reset_n) |-> !dev_data_oe) else $error("data held right after reset");
  a_atn_release: assert property (
    $rose(atn_n) |-> ack_q >= 20 * US) else $error("attention released too soon");
  a_bit_stable: assert property (
    clk_line && $past(clk_line) |-> $stable(host_data_oe))
    else $error("data moved while clock high");
  a_frame_ack: assert property (
    $fell(clk_line) && bits_q == 4'h8 |-> ##[1:16] dev_data_oe)
    else $error("no frame acknowledge after eight bits");
endmodule : sbpp_props

// >>> tb/test_serial_bus_peripheral_port.sv
`timescale 1ns/1ns
module test_serial_bus_peripheral_port;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_atn = 1'b0;
  logic tx_atn_end = 1'b0;
  logic tx_eoi = 1'b0;
  logic tx_ready, tx_done, err_absent, err_frame;
  logic rx_valid, rx_eoi, sec_valid, listener, talker;
  logic [7:0] rx_data;
  logic [4:0] sec_chan;
  sbpp_pkg::sbpp_cmd_type sec_kind;
  sbpp_pkg::sbpp_chan_type chan_class;
  int errors = 0;
  int n_tests = 0;
  int n_rx = 0;
  int n_sec = 0;
  int n_err = 0;
  logic [7:0] exp_chan;
  // Short microsecond tick keeps the run brief; all ratios stay as built
  localparam int TCK = 3;
  logic [7:0] sec_b [5] = '{8'hf1, 8'he0, 8'hfc, 8'hff, 8'h6d};
  sbpp_pkg::sbpp_cmd_type sec_k [5] = '{sbpp_pkg::SBPP_CMD_OPEN, sbpp_pkg::SBPP_CMD_CLOSE,
    sbpp_pkg::SBPP_CMD_OPEN, sbpp_pkg::SBPP_CMD_OPEN, sbpp_pkg::SBPP_CMD_SEC};
  sbpp_pkg::sbpp_chan_type sec_c [5] = '{sbpp_pkg::SBPP_CH_PROG_WRITE,
    sbpp_pkg::SBPP_CH_PROG_READ, sbpp_pkg::SBPP_CH_ANY_FILE, sbpp_pkg::SBPP_CH_UNIT_CMD,
    sbpp_pkg::SBPP_CH_OTHER};

  sbpp_if bus_i ();
  sbpp_host #(.TICK_CYC(TCK)) u_sbpp_host (.sys_clk, .reset_n, .ce(1'b1), .bus(bus_i.host),
    .tx_valid, .tx_data, .tx_atn, .tx_atn_end, .tx_eoi, .tx_ready, .tx_done, .err_absent,
    .err_frame);
  sbpp_device #(.TICK_CYC(TCK)) u_sbpp_device (.sys_clk, .reset_n, .ce(1'b1), .bus(bus_i.dev),
    .rx_valid, .rx_data, .rx_eoi, .sec_valid, .sec_kind, .sec_chan, .chan_class, .listener,
    .talker);
  sbpp_props #(.US(TCK)) u_sbpp_props (.sys_clk, .reset_n, .atn_n(bus_i.atn_n),
    .clk_line(bus_i.clk_line), .host_data_oe(bus_i.host_data_oe),
    .dev_data_oe(bus_i.dev_data_oe));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) n_rx++;
    if (sec_valid === 1'b1) n_sec++;
    if (err_absent === 1'b1 || err_frame === 1'b1) n_err++;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // One whole byte; a lost handshake shows up as a missing done
  task send(input logic [7:0] b, input logic a, input logic ae, input logic e);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    tx_valid = 1'b1;
    tx_data = b;
    tx_atn = a;
    tx_atn_end = ae;
    tx_eoi = e;
    @(posedge sys_clk);
    #1;
    tx_valid = 1'b0;
    n = 0;
    while (tx_done !== 1'b1 && n < 10000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("done", {7'h00, tx_done}, 8'h01);
    repeat (20) @(posedge sys_clk);
    #1;
  endtask : send

  task pulse_reset;
    reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
  endtask : pulse_reset

  ////////////////////////////////////////////////////////////////////////
  initial begin
    pulse_reset();
    for (int i = 0; i < 5; i++) begin
      send(8'h24, 1'b1, 1'b0, 1'b0);
      send(sec_b[i], 1'b1, 1'b1, 1'b0);
      chk("listener", {7'h00, listener}, 8'h01);
      chk("kind", {5'h00, sec_kind}, {5'h00, sec_k[i]});
      exp_chan = sec_b[i][7] ? {4'h0, sec_b[i][3:0]} : {3'h0, sec_b[i][4:0]};
      chk("chan", {3'h0, sec_chan}, exp_chan);
      chk("class", {5'h00, chan_class}, {5'h00, sec_c[i]});
    end
    chk("sec count", 8'(n_sec), 8'h05);
    send(8'ha5, 1'b0, 1'b0, 1'b1);
    chk("rx data", rx_data, 8'ha5);
    chk("rx eoi", {7'h00, rx_eoi}, 8'h01);
    send(8'h3c, 1'b0, 1'b0, 1'b0);
    chk("rx data", rx_data, 8'h3c);
    chk("rx eoi", {7'h00, rx_eoi}, 8'h00);
    chk("rx count", 8'(n_rx), 8'h02);
    send(8'h3f, 1'b1, 1'b1, 1'b0);
    chk("listener", {7'h00, listener}, 8'h00);
    send(8'h28, 1'b1, 1'b1, 1'b0);
    chk("listener", {7'h00, listener}, 8'h00);
    send(8'h44, 1'b1, 1'b1, 1'b0);
    chk("talker", {7'h00, talker}, 8'h01);
    send(8'h5f, 1'b1, 1'b1, 1'b0);
    chk("talker", {7'h00, talker}, 8'h00);
    send(8'h24, 1'b1, 1'b1, 1'b0);
    chk("listener", {7'h00, listener}, 8'h01);
    chk("bus errors", 8'(n_err), 8'h00);
    pulse_reset();
    chk("listener", {7'h00, listener}, 8'h00);
    chk("data oe", {7'h00, bus_i.dev_data_oe}, 8'h00);
    end_sim();
  end

  // Seventeen bytes of under 1700 ticks each, with margin
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule : test_serial_bus_peripheral_port
